// ### inc/tdmtx_pkg.sv
`default_nettype none
package tdmtx_pkg;
  // Clock rate and line clock loss timing
  localparam int CLK_MHZ      = 40;
  localparam int LOSS_TIME_NS = 1943; // About three periods of the slower line clock
  localparam int LOSS_CYC     = (LOSS_TIME_NS * CLK_MHZ + 999) / 1000;

  // Frame geometry
  localparam int T1_FRAME_BITS = 193;
  localparam int E1_FRAME_BITS = 256;
  localparam int T1_MF_FRAMES  = 12;
  localparam int E1_MF_FRAMES  = 16;
  localparam int T1_SIG_FRM_A  = 5;
  localparam int T1_SIG_FRM_B  = 11;
  localparam int E1_SIG_SLOT   = 16;
  localparam int CH_LSB        = 7;
  localparam int ES_DEPTH      = 2 * E1_FRAME_BITS;

  typedef logic [8:0]  tdmtx_bit_t;
  typedef logic [3:0]  tdmtx_frm_t;
  typedef logic [9:0]  tdmtx_fill_t;
  typedef logic [4:0]  tdmtx_addr_t;
  typedef logic [31:0] tdmtx_word_t;

  // Register byte offsets
  localparam tdmtx_addr_t OFF_TXCTL = 5'h00;
  localparam tdmtx_addr_t OFF_GLOBAL_CONTROL_TWO  = 5'h04;
  localparam tdmtx_addr_t OFF_MASK  = 5'h08;
  localparam tdmtx_addr_t OFF_AUX   = 5'h0c;
  localparam tdmtx_addr_t OFF_STAT  = 5'h10;

  // Field positions
  localparam int CTL_ES       = 0;
  localparam int CTL_SIG      = 1;
  localparam int CTL_E1       = 2;
  localparam int CTL_SYNC_OUT = 3;
  localparam int CTL_SYNC_MF  = 4;
  localparam int CTL_DBL      = 5;
  localparam int CTL_LOOP     = 6;
  localparam int CTL_NRZ      = 7;
  localparam int GLOBAL_CONTROL_TWO_STROBE  = 1;
  localparam int AUX_GATED    = 0;
  localparam int AUX_LOSS_SEL = 1;
  localparam int STAT_LOSS    = 0;
  localparam int STAT_SLIP    = 1;

  // Reset values
  localparam tdmtx_word_t CTL_RST  = 32'h0000_0000;
  localparam tdmtx_word_t GLOBAL_CONTROL_TWO_RST = 32'h0000_0000;
  localparam tdmtx_word_t MASK_RST = 32'h0000_0000;
  localparam tdmtx_word_t AUX_RST  = 32'h0000_0000;

  // Bits in one frame
  function automatic tdmtx_fill_t tdmtx_frame_bits(input logic e1);
    return e1 ? tdmtx_fill_t'(E1_FRAME_BITS) : tdmtx_fill_t'(T1_FRAME_BITS);
  endfunction

  // Advance a {frame, bit} position by one bit time
  function automatic logic [12:0] tdmtx_step(input logic [12:0] pos, input logic e1);
    tdmtx_bit_t b;
    tdmtx_frm_t f;
    b = pos[8:0];
    f = pos[12:9];
    if (32'(b) == (e1 ? E1_FRAME_BITS : T1_FRAME_BITS) - 1) begin
      b = '0;
      f = (32'(f) == (e1 ? E1_MF_FRAMES : T1_MF_FRAMES) - 1) ? '0 : f + 4'h1;
    end else begin
      b = b + 9'h001;
    end
    return {f, b};
  endfunction

  // Byte-lane merge for register writes
  function automatic tdmtx_word_t tdmtx_merge(input tdmtx_word_t old, input tdmtx_word_t nw,
                                              input logic [3:0] be);
    tdmtx_word_t r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction
endpackage
`default_nettype wire

// ### inc/tdmtx_es_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tdmtx_es_if;
  logic       wr_valid;
  logic [1:0] wr_data;
  logic       rd_take;
  logic [1:0] rd_data;
  logic       slip;
  logic       e1;
  modport store  (input wr_valid, wr_data, rd_take, e1, output rd_data, slip);
  modport framer (output wr_valid, wr_data, rd_take, e1, input rd_data, slip);
endinterface
`default_nettype wire

// ### rtl/tdmtx_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tdmtx_sync #(
  parameter int W = 7
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         reset,
  // Raw and synchronised levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;

  // Two flops; the first is read by the second only
  always_ff @(posedge clock) begin
    if (reset) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ### rtl/tdmtx_estore.sv
`timescale 1ns/1ps
`default_nettype none
module tdmtx_estore (
  // Clock and reset
  input  wire logic  clock,
  input  wire logic  reset,
  // Framer side
  tdmtx_es_if.store  es
);
  import tdmtx_pkg::*;

  logic [1:0]  mem_q [ES_DEPTH];
  tdmtx_fill_t wr_ptr_q;
  tdmtx_fill_t rd_ptr_q;
  tdmtx_fill_t fill_q;
  tdmtx_fill_t rd_ptr_d;
  tdmtx_fill_t fill_d;
  tdmtx_fill_t half;
  tdmtx_fill_t cap;
  logic        over;
  logic        under;
  logic        slip_q;

  // Modulo-capacity pointer advance
  function automatic tdmtx_fill_t adv(input tdmtx_fill_t p, input tdmtx_fill_t n,
                                      input tdmtx_fill_t c);
    tdmtx_fill_t s;
    s = p + n;
    return (s >= c) ? s - c : s;
  endfunction

  // Two frames of storage, sized by the current mode
  assign half       = tdmtx_frame_bits(es.e1);
  assign cap        = {half[8:0], 1'b0};
  assign over       = es.wr_valid && (fill_q == cap);
  assign under      = es.rd_take && !over && (fill_q == '0);
  assign es.rd_data = mem_q[rd_ptr_q[8:0]];
  assign es.slip    = slip_q;

  // Slips move the read side by a whole frame to keep alignment
  always_comb begin
    rd_ptr_d = rd_ptr_q;
    fill_d   = fill_q;
    if (over) begin
      rd_ptr_d = adv(rd_ptr_d, half, cap);
      fill_d   = fill_d - half;
    end
    if (es.rd_take) begin
      if (fill_d == '0) begin
        rd_ptr_d = adv(rd_ptr_d, cap - half, cap);
        fill_d   = half;
      end else begin
        rd_ptr_d = adv(rd_ptr_d, 10'h001, cap);
        fill_d   = fill_d - 10'h001;
      end
    end
    if (es.wr_valid) begin
      fill_d = fill_d + 10'h001;
    end
  end

  // Pointers and slip pulse
  always_ff @(posedge clock) begin
    if (reset) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      fill_q   <= '0;
      slip_q   <= 1'b0;
    end else begin
      rd_ptr_q <= rd_ptr_d;
      fill_q   <= fill_d;
      slip_q   <= over || under;
      if (es.wr_valid) begin
        wr_ptr_q <= adv(wr_ptr_q, 10'h001, cap);
      end
    end
  end

  // Storage is not reset; stale bits only follow a slip
  always_ff @(posedge clock) begin
    if (es.wr_valid) begin
      mem_q[wr_ptr_q[8:0]] <= es.wr_data;
    end
  end

  property p_over_slip;
    @(posedge clock) disable iff (reset)
    (es.wr_valid && fill_q == cap) |=> (slip_q && fill_q <= cap);
  endproperty
  a_over_slip: assert property (p_over_slip) else $error("overflow without slip");
endmodule
`default_nettype wire

// ### rtl/tdmtx_framer.sv
// Contract
// - Both line outputs update on each output register clock rising edge with formatter data.
// - NRZ format bit puts unipolar data on the positive output.
// - Output register clock follows line clock, or receive clock in loopback.
// - Payload sampled on line clock fall, or backplane clock fall with store on.
// - Signaling bits sampled like payload and inserted into the outgoing stream.
// - Boundary sync pin works as input pulse or as output pulse.
// - T1 frame sync output may widen to two bits on signaling frames.
// - Backplane sync sets backplane boundaries, used only with store on.
// - Channel gate output follows a per-channel programmed level.
// - Gate and strobe follow line clock, or backplane clock with store on.
// - Strobe output is high during the last bit of every channel.
// - Strobe may instead be a bit clock gated to selected channels.
// - Frames hold 24 channels in T1 and 32 in E1.
// - Global select bit 1 picks gate (0) or strobe (1) output.
// - Line clock loss flagged after about three idle periods.
`timescale 1ns/1ps
`default_nettype none
module tdmtx_framer (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               reset,
  // Avalon-MM register slave
  input  wire tdmtx_pkg::tdmtx_addr_t avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire tdmtx_pkg::tdmtx_word_t avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output tdmtx_pkg::tdmtx_word_t  avs_readdata,
  output logic                    avs_waitrequest,
  // Line side
  input  wire logic               tx_line_clock,
  input  wire logic               rx_line_clock,
  output logic                    tx_line_pos_out,
  output logic                    tx_line_neg_out,
  // Backplane side
  input  wire logic               tx_backplane_clock,
  input  wire logic               tx_serial_payload_in,
  input  wire logic               tx_signaling_in,
  input  wire logic               tx_backplane_boundary_sync,
  // Boundary sync pin
  input  wire logic               tx_boundary_sync_in,
  output logic                    tx_boundary_sync_out,
  output logic                    tx_boundary_sync_oe_n,
  // Channel pin and loss indicator
  output logic                    tx_channel_pin,
  output logic                    tx_clock_loss_flag
);
  import tdmtx_pkg::*;

  logic [6:0]  s;
  logic [2:0]  prev_q;
  tdmtx_word_t ctl_q;
  tdmtx_word_t global_control_two_q;
  tdmtx_word_t mask_q;
  tdmtx_word_t aux_q;
  logic        slip_q;
  logic [12:0] line_pos_q;
  logic [12:0] bp_pos_q;
  logic        fmt_bit_q;
  logic        mark_q;
  logic        gate_q;
  logic        strobe_q;
  logic [12:0] idle_q;
  logic        loss_q;

  tdmtx_es_if es_if ();

  // Every pin level passes two flops first
  tdmtx_sync #(
    .W (7)
  ) u_sync (
    .clock (clock),
    .reset (reset),
    .din   ({rx_line_clock, tx_backplane_clock, tx_line_clock, tx_backplane_boundary_sync,
             tx_boundary_sync_in, tx_signaling_in, tx_serial_payload_in}),
    .dout  (s)
  );

  tdmtx_estore u_estore (
    .clock (clock),
    .reset (reset),
    .es    (es_if.store)
  );

  // Control fields
  wire es_on    = ctl_q[CTL_ES];
  wire sig_on   = ctl_q[CTL_SIG];
  wire e1       = ctl_q[CTL_E1];
  wire sync_out = ctl_q[CTL_SYNC_OUT];
  wire sync_mf  = ctl_q[CTL_SYNC_MF];
  wire dbl_on   = ctl_q[CTL_DBL];
  wire loop_on  = ctl_q[CTL_LOOP];
  wire nrz_on   = ctl_q[CTL_NRZ];
  wire sel_strb = global_control_two_q[GLOBAL_CONTROL_TWO_STROBE];
  wire gated_on = aux_q[AUX_GATED];

  // Clock edges seen on the synchronised levels
  wire line_fall = prev_q[0] && !s[4];
  wire line_rise = !prev_q[0] && s[4];
  wire bp_fall   = prev_q[1] && !s[5];
  wire rx_rise   = !prev_q[2] && s[6];
  wire out_tick  = loop_on ? rx_rise : line_rise;
  wire in_tick   = es_on ? bp_fall : line_fall;

  // Line-side position and channel decode
  wire [8:0] lbit   = line_pos_q[8:0];
  wire [3:0] lfrm   = line_pos_q[12:9];
  wire       l_fbit = !e1 && (lbit == 9'h000);
  wire [7:0] l_cpos = e1 ? lbit[7:0] : 8'(lbit - 9'h001);
  wire       t1_sfr = (32'(lfrm) == T1_SIG_FRM_A) || (32'(lfrm) == T1_SIG_FRM_B);
  wire       sig_slot = e1 ? (32'(l_cpos[7:3]) == E1_SIG_SLOT)
                           : (t1_sfr && !l_fbit && 32'(l_cpos[2:0]) == CH_LSB);

  // Source bits: direct pins or the elastic store
  wire [1:0] src     = es_on ? es_if.rd_data : {s[1], s[0]};
  wire       fmt_bit = (sig_on && sig_slot) ? src[1] : src[0];

  // Boundary pulses from the sync pins: line pin in input mode only, backplane pin with store on only
  wire line_bnd = !sync_out && s[2];
  wire bp_bnd   = es_on && s[3];

  // Strobe timing source depends on the store
  wire [12:0] t_pos  = es_on ? bp_pos_q : line_pos_q;
  wire [8:0]  tbit   = t_pos[8:0];
  wire        t_fbit = !e1 && (tbit == 9'h000);
  wire [7:0]  t_cpos = e1 ? tbit[7:0] : 8'(tbit - 9'h001);
  wire        t_gate = !t_fbit && mask_q[t_cpos[7:3]];
  wire        t_lsb  = !t_fbit && (32'(t_cpos[2:0]) == CH_LSB);
  wire        t_clk  = es_on ? s[5] : s[4];

  // Sync output pulse; T1 frame mode may widen on signaling frames
  wire sync_first = (lbit == 9'h000) && (!sync_mf || lfrm == 4'h0);
  wire sync_wide  = dbl_on && !e1 && !sync_mf && t1_sfr && (lbit == 9'h001);

  // Register decode
  wire hit_ctl  = avs_address == OFF_TXCTL;
  wire hit_global_control_two = avs_address == OFF_GLOBAL_CONTROL_TWO;
  wire hit_mask = avs_address == OFF_MASK;
  wire hit_aux  = avs_address == OFF_AUX;
  wire hit_stat = avs_address == OFF_STAT;
  wire bus_wr   = avs_write && !avs_waitrequest; // Lands on the edge the master sees the answer
  wire bus_rd   = avs_read && avs_waitrequest;
  wire slip_clr = bus_wr && hit_stat && avs_byteenable[0] && avs_writedata[STAT_SLIP];
  tdmtx_word_t stat_word;
  tdmtx_word_t rd_word;
  assign stat_word = tdmtx_word_t'({slip_q, loss_q});
  assign rd_word   = hit_ctl  ? ctl_q  :
                     hit_global_control_two ? global_control_two_q :
                     hit_mask ? mask_q :
                     hit_aux  ? aux_q  :
                     hit_stat ? stat_word : '0;

  // Elastic store hookup
  assign es_if.wr_valid = es_on && bp_fall;
  assign es_if.wr_data  = {s[1], s[0]};
  assign es_if.rd_take  = es_on && line_fall;
  assign es_if.e1       = e1;

  // Edge history
  always_ff @(posedge clock) begin
    if (reset) begin
      prev_q <= '0;
    end else begin
      prev_q <= {s[6], s[5], s[4]};
    end
  end

  // Bus slave: one wait cycle, then the answer
  always_ff @(posedge clock) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (bus_rd) begin
        avs_readdata <= rd_word;
      end
    end
  end

  // Control registers; unmapped writes are dropped
  always_ff @(posedge clock) begin
    if (reset) begin
      ctl_q  <= CTL_RST;
      global_control_two_q <= GLOBAL_CONTROL_TWO_RST;
      mask_q <= MASK_RST;
      aux_q  <= AUX_RST;
    end else if (bus_wr) begin
      if (hit_ctl) ctl_q <= tdmtx_merge(ctl_q, avs_writedata, avs_byteenable);
      if (hit_global_control_two) global_control_two_q <= tdmtx_merge(global_control_two_q, avs_writedata, avs_byteenable);
      if (hit_mask) mask_q <= tdmtx_merge(mask_q, avs_writedata, avs_byteenable);
      if (hit_aux) aux_q <= tdmtx_merge(aux_q, avs_writedata, avs_byteenable);
    end
  end

  // Sticky slip flag; a new slip beats the clear
  always_ff @(posedge clock) begin
    if (reset) begin
      slip_q <= 1'b0;
    end else begin
      slip_q <= es_if.slip || (slip_q && !slip_clr);
    end
  end

  // Line and backplane frame positions
  always_ff @(posedge clock) begin
    if (reset) begin
      line_pos_q <= '0;
      bp_pos_q   <= '0;
    end else begin
      if (line_fall) begin
        line_pos_q <= line_bnd ? {(sync_mf ? 4'h0 : lfrm), 9'h000}
                               : tdmtx_step(line_pos_q, e1);
      end
      if (bp_fall) begin
        bp_pos_q <= bp_bnd ? {(sync_mf ? 4'h0 : bp_pos_q[12:9]), 9'h000}
                           : tdmtx_step(bp_pos_q, e1);
      end
    end
  end

  // Formatter bit is taken on the falling line edge
  always_ff @(posedge clock) begin
    if (reset) begin
      fmt_bit_q <= 1'b0;
    end else if (line_fall) begin
      fmt_bit_q <= fmt_bit;
    end
  end

  // Line encoder; alternate mark inversion or NRZ, no zero substitution
  always_ff @(posedge clock) begin
    if (reset) begin
      tx_line_pos_out <= 1'b0;
      tx_line_neg_out <= 1'b0;
      mark_q          <= 1'b0;
    end else if (out_tick) begin
      if (nrz_on) begin
        tx_line_pos_out <= fmt_bit_q;
        tx_line_neg_out <= 1'b0;
      end else begin
        tx_line_pos_out <= fmt_bit_q && !mark_q;
        tx_line_neg_out <= fmt_bit_q && mark_q;
        mark_q          <= mark_q ^ fmt_bit_q;
      end
    end
  end

  // Sync pin drive; enable is low while driving
  always_ff @(posedge clock) begin
    if (reset) begin
      tx_boundary_sync_out  <= 1'b0;
      tx_boundary_sync_oe_n <= 1'b1;
    end else begin
      tx_boundary_sync_oe_n <= !sync_out;
      if (!sync_out) begin
        tx_boundary_sync_out <= 1'b0;
      end else if (line_fall) begin
        tx_boundary_sync_out <= sync_first || sync_wide;
      end
    end
  end

  // Gate and strobe state on the chosen bit clock
  always_ff @(posedge clock) begin
    if (reset) begin
      gate_q   <= 1'b0;
      strobe_q <= 1'b0;
    end else if (in_tick) begin
      gate_q   <= t_gate;
      strobe_q <= t_lsb;
    end
  end

  // Pin mux; the gated clock lags the pin level by the sync delay
  always_ff @(posedge clock) begin
    if (reset) begin
      tx_channel_pin <= 1'b0;
    end else begin
      tx_channel_pin <= !sel_strb ? gate_q :
                        gated_on  ? (t_clk && t_gate) : strobe_q;
    end
  end

  // Line clock watchdog
  always_ff @(posedge clock) begin
    if (reset) begin
      idle_q             <= '0;
      loss_q             <= 1'b0;
      tx_clock_loss_flag <= 1'b0;
    end else begin
      idle_q <= (line_fall || line_rise) ? '0 :
                (32'(idle_q) >= LOSS_CYC) ? idle_q : idle_q + 13'h0001;
      loss_q <= !(line_fall || line_rise) && (32'(idle_q) >= LOSS_CYC - 1);
      tx_clock_loss_flag <= loss_q && aux_q[AUX_LOSS_SEL];
    end
  end

  property p_nrz;
    @(posedge clock) disable iff (reset)
    (out_tick && nrz_on) |=> (!tx_line_neg_out && tx_line_pos_out == $past(fmt_bit_q));
  endproperty
  a_nrz: assert property (p_nrz) else $error("nrz output wrong");

  property p_ami;
    @(posedge clock) disable iff (reset)
    (out_tick && !nrz_on) |=> (!(tx_line_pos_out && tx_line_neg_out)
                               && ((tx_line_pos_out || tx_line_neg_out) == $past(fmt_bit_q)));
  endproperty
  a_ami: assert property (p_ami) else $error("bipolar output wrong");

  property p_loss_set;
    @(posedge clock) disable iff (reset)
    (32'(idle_q) == LOSS_CYC - 1 && !line_fall && !line_rise) |=> loss_q;
  endproperty
  a_loss_set: assert property (p_loss_set) else $error("clock loss not flagged");

  property p_loss_clr;
    @(posedge clock) disable iff (reset)
    (line_fall || line_rise) |=> (!loss_q ##1 !loss_q);
  endproperty
  a_loss_clr: assert property (p_loss_clr) else $error("loss flag after edge");

  property p_strobe;
    @(posedge clock) disable iff (reset)
    (in_tick && t_lsb) |=> strobe_q;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe missing on channel lsb");

  property p_gate;
    @(posedge clock) disable iff (reset)
    (in_tick && !sel_strb) |=> (gate_q == $past(t_gate))
                               ##1 ($past(sel_strb) || tx_channel_pin == $past(gate_q));
  endproperty
  a_gate: assert property (p_gate) else $error("channel gate wrong");

  property p_sync_oe;
    @(posedge clock) disable iff (reset)
    sync_out |=> !tx_boundary_sync_oe_n;
  endproperty
  a_sync_oe: assert property (p_sync_oe) else $error("sync pin not driven");

  property p_wrap;
    @(posedge clock) disable iff (reset)
    (line_fall && !line_bnd && 32'(lbit) == E1_FRAME_BITS - 1 && e1) |=> (line_pos_q[8:0] == 9'h000);
  endproperty
  a_wrap: assert property (p_wrap) else $error("frame did not wrap");

  property p_bus;
    @(posedge clock) disable iff (reset)
    ((avs_read || avs_write) && avs_waitrequest) |=> (!avs_waitrequest ##1 avs_waitrequest);
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer timing wrong");
endmodule
`default_nettype wire

// ### dv/tdmtx_partner.sv
`timescale 1ns/1ps
`default_nettype none
module tdmtx_partner (
  // Controls
  input  wire logic run,
  input  wire logic e1,
  input  wire logic pat,
  // Line and backplane pins
  output logic      line_clock,
  output logic      payload,
  output logic      signaling,
  output logic      bp_clock,
  output logic      bp_sync
);
  // Store unused, so backplane pins are held low
  assign bp_clock = 1'b0;
  assign bp_sync  = 1'b0;

  // Line clock at 2.048 or 1.544 MHz; parks low when stopped
  initial begin
    line_clock = 1'b0;
    forever begin
      if (run) begin
        #(e1 ? 244 : 324) line_clock = ~line_clock;
      end else begin
        #25 line_clock = 1'b0;
      end
    end
  end

  // New bit after each rise, stable across the sampling fall
  initial payload = 1'b0;
  initial signaling = 1'b1;
  always @(posedge line_clock) begin
    payload   <= pat;
    signaling <= ~pat;
  end
endmodule
`default_nettype wire

// ### dv/tdmtx_framer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tdmtx_framer_tb;
  import tdmtx_pkg::*;
  // Bus side
  logic        clock, reset, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_byteenable;
  tdmtx_addr_t avs_address;
  tdmtx_word_t avs_writedata, avs_readdata, rd;
  // Pins
  logic        line_clock, payload, signaling, bp_clock, bp_sync, run, e1, pat;
  logic        pos, neg, sync_out, sync_oe_n, ch_pin, loss, bsync;
  int          error_cnt, num_checks, n_bits, n_ch, n_sy, n_syh, n_pos, n_neg, n_both;

  tdmtx_partner tdmtx_partner_i (.run(run), .e1(e1), .pat(pat), .line_clock(line_clock),
    .payload(payload), .signaling(signaling), .bp_clock(bp_clock), .bp_sync(bp_sync));

  tdmtx_framer tdmtx_framer_i (.clock(clock), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tx_line_clock(line_clock), .rx_line_clock(line_clock),
    .tx_line_pos_out(pos), .tx_line_neg_out(neg), .tx_backplane_clock(bp_clock),
    .tx_serial_payload_in(payload), .tx_signaling_in(signaling),
    .tx_backplane_boundary_sync(bp_sync), .tx_boundary_sync_in(bsync),
    .tx_boundary_sync_out(sync_out), .tx_boundary_sync_oe_n(sync_oe_n),
    .tx_channel_pin(ch_pin), .tx_clock_loss_flag(loss));

  // 40 MHz system clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input tdmtx_word_t seen, input tdmtx_word_t exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input tdmtx_addr_t a, input tdmtx_word_t d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clock);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= ~wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 40) begin
      error_cnt++;
      conclude();
    end
  endtask

  // Count pin events over a number of line bits
  task automatic watch(input int bits);
    logic lc, cp, sp;
    int   n;
    lc = line_clock;
    cp = ch_pin;
    sp = sync_out;
    n = 0;
    n_bits = 0;
    n_ch = 0;
    n_sy = 0;
    n_syh = 0;
    n_pos = 0;
    n_neg = 0;
    n_both = 0;
    while (n_bits < bits && n < 70000) begin
      @(posedge clock);
      n++;
      if (line_clock && !lc) begin
        n_bits++;
        n_pos += int'(pos);
        n_neg += int'(neg);
        n_both += int'(pos & neg);
        n_syh += int'(sync_out);
      end
      n_ch += int'(ch_pin & ~cp);
      n_sy += int'(sync_out & ~sp);
      lc = line_clock;
      cp = ch_pin;
      sp = sync_out;
    end
    if (n >= 70000) begin
      error_cnt++;
      conclude();
    end
  endtask

  // Program control, global select, channel mask and aux, then settle
  task automatic mode(input tdmtx_word_t c, input tdmtx_word_t g, input tdmtx_word_t m,
                      input tdmtx_word_t x);
    e1 = c[CTL_E1];
    bus(1'b1, OFF_TXCTL, c, 4'hf);
    bus(1'b1, OFF_GLOBAL_CONTROL_TWO, g, 4'hf);
    bus(1'b1, OFF_MASK, m, 4'hf);
    bus(1'b1, OFF_AUX, x, 4'hf);
    watch(24);
  endtask

  initial begin
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    avs_byteenable = 4'h0;
    run = 1'b1;
    e1 = 1'b0;
    pat = 1'b1;
    bsync = 1'b0;
    error_cnt = 0;
    num_checks = 0;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1;
    chk("sync_oe_n", 32'(sync_oe_n), 32'h1);
    // Reset values, unmapped offset included
    for (int a = 0; a < 24; a += 4) begin
      bus(1'b0, tdmtx_addr_t'(a), '0, 4'h0);
      chk("reset read", rd, 32'h0);
    end
    bus(1'b1, OFF_GLOBAL_CONTROL_TWO, 32'h2, 4'h0);
    bus(1'b1, 5'h14, 32'hff, 4'hf);
    bus(1'b0, OFF_GLOBAL_CONTROL_TWO, '0, 4'h0);
    chk("masked write", rd, 32'h0);
    bus(1'b0, 5'h14, '0, 4'h0);
    chk("unmapped", rd, 32'h0);
    // E1 bipolar, all ones: marks alternate, never both
    mode(32'h04, 32'h0, 32'h0, 32'h0);
    watch(256);
    chk("both high", 32'(n_both), 32'h0);
    chk("marks pos", 32'(n_pos), 32'h80);
    chk("marks neg", 32'(n_neg), 32'h80);
    chk("gate off", 32'(n_ch), 32'h0);
    // NRZ: payload ones on positive output only
    mode(32'h84, 32'h0, 32'h0, 32'h0);
    watch(256);
    chk("nrz neg", 32'(n_neg), 32'h0);
    chk("nrz ones", 32'(n_pos), 32'(E1_FRAME_BITS));
    // Signaling slot carries the inverted pin; loopback output timing
    mode(32'hc6, 32'h0, 32'h0, 32'h0);
    watch(256);
    chk("sig slot", 32'(n_pos), 32'(E1_FRAME_BITS - 8));
    // Gate on channels 0 and 2: two pulses a frame
    mode(32'h04, 32'h0, 32'h5, 32'h0);
    watch(256);
    chk("gate e1", 32'(n_ch), 32'h2);
    // Boundary input pulse for one bit; channel 1 gate opens nine bits on
    mode(32'h04, 32'h0, 32'h2, 32'h0);
    bsync <= 1'b1;
    watch(1);
    bsync <= 1'b0;
    watch(8);
    chk("bnd early", 32'(n_ch), 32'h0);
    watch(1);
    chk("bnd gate", 32'(n_ch), 32'h1);
    // Strobe: one pulse per channel
    mode(32'h04, 32'h2, 32'h0, 32'h0);
    watch(256);
    chk("strobe e1", 32'(n_ch), 32'h20);
    // Gated bit clock on channel 0: eight bit pulses
    mode(32'h04, 32'h2, 32'h1, 32'h1);
    watch(256);
    chk("gated clk", 32'(n_ch), 32'h8);
    // Sync pin as frame output
    mode(32'h0c, 32'h0, 32'h0, 32'h0);
    watch(256);
    chk("sync oe", 32'(sync_oe_n), 32'h0);
    chk("sync e1", 32'(n_sy), 32'h1);
    // T1 frame sync over half a multiframe: six pulses, one widened, 24 strobes a frame
    mode(32'h28, 32'h2, 32'h0, 32'h0);
    watch(T1_FRAME_BITS * T1_MF_FRAMES / 2);
    chk("sync t1", 32'(n_sy), 32'h6);
    chk("wide bits", 32'(n_syh), 32'h7);
    chk("strobe t1", 32'(n_ch), 32'(24 * T1_MF_FRAMES / 2));
    // Line clock loss on the flag pin, with the aux select bit set
    mode(32'h04, 32'h0, 32'h0, 32'h2);
    run = 1'b0;
    repeat (LOSS_CYC + 40) @(posedge clock);
    #1;
    chk("loss flag", 32'(loss), 32'h1);
    bus(1'b0, OFF_STAT, '0, 4'h0);
    chk("loss stat", 32'(rd[STAT_LOSS]), 32'h1);
    run = 1'b1;
    watch(8);
    chk("loss clear", 32'(loss), 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
